// File: verilog/fdm_pkg.sv
// package: constants and types for the flash data memory controller
package fdm_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int MEM_BYTES = 64;
	localparam int ROW_BYTES = 8;
	localparam int ROW_HI = 5;
	localparam int ROW_LO = 3;
	localparam int ROW_W = 3;
	localparam int COL_W = 3;
	// bit positions of the control register
	localparam int BIT_RD = 0;
	localparam int BIT_WR = 1;
	localparam int BIT_ARRAY_WRITE_ENABLE_BIT = 2;
	localparam int BIT_FREE = 4;
	localparam int BIT_W = 3;
	localparam int CTRL_W = 5;
	// special function register selectors
	localparam logic [1:0] SEL_ADDR = 2'h0;
	localparam logic [1:0] SEL_DATA = 2'h1;
	localparam logic [1:0] SEL_CTRL = 2'h2;
	// core instruction kinds on the register port
	localparam logic [1:0] OP_NONE = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_BITSET = 2'h2;
	localparam logic [1:0] OP_READ = 2'h3;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// busy length of an array operation, in clocks
	localparam int ERASE_CYCLES = 4;
	localparam int WRITE_CYCLES = 2;
	localparam int READ_CYCLES = 1;
	localparam int CNT_W = 3;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01,
		ST_DONE = 2'b11
	} fdm_state_t;
endpackage

// File: verilog/fdm_if.sv
// interface: core instruction port of the flash data controller
interface fdm_if;
	logic [1:0] op;
	logic [1:0] sel;
	logic [fdm_pkg::BIT_W-1:0] bitNum;
	logic [7:0] wrData;
	logic [7:0] rdData;
	logic stall;
	modport ctrl (input op, input sel, input bitNum, input wrData, output rdData, output stall);
	modport core (output op, output sel, output bitNum, output wrData, input rdData, input stall);
endinterface

// File: verilog/fdm_array.sv
// module: 64-byte flash array with row erase and byte program
module fdm_array (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// array commands
	input wire logic readEn,
	input wire logic eraseEn,
	input wire logic progEn,
	input wire logic [fdm_pkg::ADDR_W-1:0] addr,
	input wire logic [7:0] progData,
	// read data
	output logic [7:0] rdData
);
	logic [7:0] mem [fdm_pkg::MEM_BYTES];
	logic [7:0] next_rdData;

	always_comb begin
		next_rdData = rdData;
		if (readEn) begin
			next_rdData = mem[addr];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdData <= fdm_pkg::ZERO_BYTE;
		end else begin
			rdData <= next_rdData;
		end
	end

	// contents survive reset, as flash does
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < fdm_pkg::MEM_BYTES; i++) begin
			if (eraseEn && (i / fdm_pkg::ROW_BYTES) == int'(addr[fdm_pkg::ROW_HI:fdm_pkg::ROW_LO])) begin
				mem[i] <= fdm_pkg::ERASED_BYTE;
			end
		end
		if (progEn) begin
			mem[addr] <= mem[addr] & progData;
		end
	end
endmodule

// File: verilog/fdm_ctrl.sv
// module: flash data memory controller, device end
module fdm_ctrl (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// core port
	fdm_if.ctrl bus
);
	logic [fdm_pkg::ADDR_W-1:0] addrReg;
	logic [7:0] dataReg;
	logic rdBit, wrBit, wrenBit, freeBit;
	logic wrenAge, freeAge;
	logic [fdm_pkg::CNT_W-1:0] cnt;
	logic isRead, isErase;
	fdm_pkg::fdm_state_t state;
	logic [7:0] rdData;
	logic stall;
	logic [fdm_pkg::ADDR_W-1:0] next_addrReg;
	logic [7:0] next_dataReg;
	logic next_rdBit, next_wrBit, next_wrenBit, next_freeBit;
	logic next_wrenAge, next_freeAge;
	logic [fdm_pkg::CNT_W-1:0] next_cnt;
	logic next_isRead, next_isErase;
	fdm_pkg::fdm_state_t next_state;
	logic [7:0] next_rdData;
	logic next_stall;
	logic arrRead, arrErase, arrProg, loadRead;
	logic [7:0] arrData;

	function automatic logic isSet(input logic [1:0] op, input logic [1:0] sel,
			input logic [fdm_pkg::BIT_W-1:0] b, input int pos);
		isSet = (op == fdm_pkg::OP_BITSET) && (sel == fdm_pkg::SEL_CTRL) && (int'(b) == pos);
	endfunction

	function automatic logic [7:0] ctrlView(input logic rd, input logic wr,
			input logic we, input logic fr);
		logic [7:0] v;
		v = fdm_pkg::ZERO_BYTE;
		v[fdm_pkg::BIT_RD] = rd;
		v[fdm_pkg::BIT_WR] = wr;
		v[fdm_pkg::BIT_ARRAY_WRITE_ENABLE_BIT] = we;
		v[fdm_pkg::BIT_FREE] = fr;
		ctrlView = v;
	endfunction

	fdm_array u_array (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.readEn(arrRead),
		.eraseEn(arrErase),
		.progEn(arrProg),
		.addr(addrReg),
		.progData(dataReg),
		.rdData(arrData)
	);

	always_comb begin
		next_addrReg = addrReg;
		next_dataReg = dataReg;
		next_rdBit = rdBit;
		next_wrBit = wrBit;
		next_wrenBit = wrenBit;
		next_freeBit = freeBit;
		next_wrenAge = 1'b0;
		next_freeAge = 1'b0;
		next_cnt = cnt;
		next_isRead = isRead;
		next_isErase = isErase;
		next_state = state;
		next_rdData = rdData;
		next_stall = stall;
		arrRead = 1'b0;
		arrErase = 1'b0;
		arrProg = 1'b0;
		loadRead = 1'b0;
		case (state)
			fdm_pkg::ST_IDLE: begin
				// drops come before sets, so a fresh set wins
				// erase select needs enable on the very next instruction
				if (freeBit && freeAge && !isSet(bus.op, bus.sel, bus.bitNum, fdm_pkg::BIT_ARRAY_WRITE_ENABLE_BIT)) begin
					next_freeBit = 1'b0;
				end
				// enable needs trigger on the very next instruction
				if (wrenBit && wrenAge && !isSet(bus.op, bus.sel, bus.bitNum, fdm_pkg::BIT_WR)) begin
					next_wrenBit = 1'b0;
					// an abandoned unlock must not leave erase armed
					next_freeBit = 1'b0;
				end
				// array is never mapped; only these selectors reach it
				if (bus.op == fdm_pkg::OP_WRITE) begin
					case (bus.sel)
						fdm_pkg::SEL_ADDR: next_addrReg = bus.wrData[fdm_pkg::ADDR_W-1:0];
						fdm_pkg::SEL_DATA: next_dataReg = bus.wrData;
						// erase select taken from a plain write as well as a bit set, enable bits are not
						fdm_pkg::SEL_CTRL: begin
							next_freeBit = bus.wrData[fdm_pkg::BIT_FREE];
							next_freeAge = bus.wrData[fdm_pkg::BIT_FREE];
						end
						default: next_addrReg = addrReg;
					endcase
				end
				if (isSet(bus.op, bus.sel, bus.bitNum, fdm_pkg::BIT_FREE)) begin
					next_freeBit = 1'b1;
					next_freeAge = 1'b1;
				end
				if (isSet(bus.op, bus.sel, bus.bitNum, fdm_pkg::BIT_ARRAY_WRITE_ENABLE_BIT)) begin
					next_wrenBit = 1'b1;
					next_wrenAge = 1'b1;
				end
				if (isSet(bus.op, bus.sel, bus.bitNum, fdm_pkg::BIT_RD)) begin
					// read only by a single-bit set; array is read now, data reaches the data register in ST_DONE
					next_rdBit = 1'b1;
					next_isRead = 1'b1;
					next_cnt = fdm_pkg::CNT_W'(fdm_pkg::READ_CYCLES);
					next_state = fdm_pkg::ST_BUSY;
					next_stall = 1'b1;
					arrRead = 1'b1;
				end else if (isSet(bus.op, bus.sel, bus.bitNum, fdm_pkg::BIT_WR)
						&& wrenBit && wrenAge) begin
					// erase when select still armed, else byte write
					next_wrBit = 1'b1;
					next_isRead = 1'b0;
					next_isErase = freeBit;
					next_cnt = freeBit ? fdm_pkg::CNT_W'(fdm_pkg::ERASE_CYCLES)
						: fdm_pkg::CNT_W'(fdm_pkg::WRITE_CYCLES);
					next_state = fdm_pkg::ST_BUSY;
					next_stall = 1'b1;
				end
			end
			fdm_pkg::ST_BUSY: begin
				// core is held; op, bit and data are ignored here, sel still picks the read data unless a read is loading
				if (isRead) begin
					loadRead = 1'b1;
					next_rdData = arrData;
				end
				next_cnt = cnt - 1'b1;
				if (cnt == fdm_pkg::CNT_W'(1)) begin
					if (!isRead) begin
						arrErase = isErase;
						arrProg = !isErase;
					end
					next_state = fdm_pkg::ST_DONE;
				end
			end
			fdm_pkg::ST_DONE: begin
				// clear triggers and enables, release the core
				next_rdBit = 1'b0;
				next_wrBit = 1'b0;
				next_wrenBit = 1'b0;
				next_freeBit = 1'b0;
				if (isRead) begin
					next_dataReg = rdData;
				end
				next_stall = 1'b0;
				next_state = fdm_pkg::ST_IDLE;
			end
			default: next_state = fdm_pkg::ST_IDLE;
		endcase
		// read data path of the register port
		if (!loadRead) begin
			case (bus.sel)
				fdm_pkg::SEL_ADDR: next_rdData = {{(8 - fdm_pkg::ADDR_W){1'b0}}, next_addrReg};
				fdm_pkg::SEL_DATA: next_rdData = next_dataReg;
				fdm_pkg::SEL_CTRL: next_rdData = ctrlView(next_rdBit, next_wrBit,
					next_wrenBit, next_freeBit);
				default: next_rdData = fdm_pkg::ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			addrReg <= '0;
			dataReg <= fdm_pkg::ZERO_BYTE;
			rdBit <= 1'b0;
			wrBit <= 1'b0;
			wrenBit <= 1'b0;
			freeBit <= 1'b0;
			wrenAge <= 1'b0;
			freeAge <= 1'b0;
			cnt <= '0;
			isRead <= 1'b0;
			isErase <= 1'b0;
			state <= fdm_pkg::ST_IDLE;
			rdData <= fdm_pkg::ZERO_BYTE;
			stall <= 1'b0;
		end else begin
			addrReg <= next_addrReg;
			dataReg <= next_dataReg;
			rdBit <= next_rdBit;
			wrBit <= next_wrBit;
			wrenBit <= next_wrenBit;
			freeBit <= next_freeBit;
			wrenAge <= next_wrenAge;
			freeAge <= next_freeAge;
			cnt <= next_cnt;
			isRead <= next_isRead;
			isErase <= next_isErase;
			state <= next_state;
			rdData <= next_rdData;
			stall <= next_stall;
		end
	end

	assign bus.rdData = rdData;
	assign bus.stall = stall;
endmodule

// File: verilog/fdm_core.sv
// module: core-side end issuing register and bit-set instructions
module fdm_core (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// controller port
	fdm_if.core bus,
	// user instruction request
	input wire logic reqValid,
	input wire logic [1:0] reqOp,
	input wire logic [1:0] reqSel,
	input wire logic [fdm_pkg::BIT_W-1:0] reqBit,
	input wire logic [7:0] reqData,
	// user status
	output logic reqReady,
	output logic [7:0] rspData
);
	logic [1:0] op;
	logic [1:0] sel;
	logic [fdm_pkg::BIT_W-1:0] bitNum;
	logic [7:0] wrData;
	logic [1:0] next_op;
	logic [1:0] next_sel;
	logic [fdm_pkg::BIT_W-1:0] next_bitNum;
	logic [7:0] next_wrData;
	logic next_reqReady;
	logic [7:0] next_rspData;

	// bit sets that may start work; unlock steps stay back to back
	function automatic logic holdsCore(input logic [1:0] o, input logic [1:0] s,
			input logic [fdm_pkg::BIT_W-1:0] b);
		holdsCore = (o == fdm_pkg::OP_BITSET) && (s == fdm_pkg::SEL_CTRL)
			&& (b != fdm_pkg::BIT_W'(fdm_pkg::BIT_FREE))
			&& (b != fdm_pkg::BIT_W'(fdm_pkg::BIT_ARRAY_WRITE_ENABLE_BIT));
	endfunction

	// one instruction per clock, none while stalled; sequences are software's job
	always_comb begin
		next_op = fdm_pkg::OP_NONE;
		next_sel = sel;
		next_bitNum = bitNum;
		next_wrData = wrData;
		next_rspData = bus.rdData;
		// taken only while ready already shows, so each accept is seen once
		if (reqValid && reqReady) begin
			next_op = reqOp;
			next_sel = reqSel;
			next_bitNum = reqBit;
			next_wrData = reqData;
		end
		// a trigger on the port stalls the controller one edge later
		next_reqReady = !bus.stall && !holdsCore(op, sel, bitNum)
			&& !holdsCore(next_op, next_sel, next_bitNum);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			op <= fdm_pkg::OP_NONE;
			sel <= fdm_pkg::SEL_ADDR;
			bitNum <= '0;
			wrData <= fdm_pkg::ZERO_BYTE;
			reqReady <= 1'b0;
			rspData <= fdm_pkg::ZERO_BYTE;
		end else begin
			op <= next_op;
			sel <= next_sel;
			bitNum <= next_bitNum;
			wrData <= next_wrData;
			reqReady <= next_reqReady;
			rspData <= next_rspData;
		end
	end

	assign bus.op = op;
	assign bus.sel = sel;
	assign bus.bitNum = bitNum;
	assign bus.wrData = wrData;
endmodule

// File: bench/fdm_asserts.sv
// checker: stall timing and unlock rules on the core port
module fdm_asserts (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// core port
	input wire logic [1:0] op,
	input wire logic [1:0] sel,
	input wire logic [fdm_pkg::BIT_W-1:0] bitNum,
	input wire logic [7:0] wrData,
	input wire logic [7:0] rdData,
	input wire logic stall
);
	logic setCtl, setWr, setRd, setWren, setFree;
	logic lastWren, lastFree, eraseArm, next_lastWren, next_lastFree, next_eraseArm;
	logic [5:0] addrReg, next_addrReg;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	assign setCtl = !stall && op == fdm_pkg::OP_BITSET && sel == fdm_pkg::SEL_CTRL;
	assign setWr = setCtl && bitNum == fdm_pkg::BIT_WR;
	assign setRd = setCtl && bitNum == fdm_pkg::BIT_RD;
	assign setWren = setCtl && bitNum == fdm_pkg::BIT_ARRAY_WRITE_ENABLE_BIT;
	// erase select is taken from plain writes as well
	assign setFree = (setCtl && bitNum == fdm_pkg::BIT_FREE)
		|| (!stall && op == fdm_pkg::OP_WRITE && sel == fdm_pkg::SEL_CTRL && wrData[4]);
	always_comb begin
		next_lastWren = setWren;
		next_lastFree = setFree;
		next_eraseArm = setWren && lastFree;
		next_addrReg = addrReg;
		if (!stall && op == fdm_pkg::OP_WRITE && sel == fdm_pkg::SEL_ADDR) begin
			next_addrReg = wrData[5:0];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lastWren <= 1'b0;
			lastFree <= 1'b0;
			eraseArm <= 1'b0;
			addrReg <= 6'h00;
		end else begin
			lastWren <= next_lastWren;
			lastFree <= next_lastFree;
			eraseArm <= next_eraseArm;
			addrReg <= next_addrReg;
		end
	end
	AST_READ_STALL: assert property (setRd |=> stall [*2] ##1 !stall)
		else $error("read stall length wrong");
	AST_WRITE_STALL: assert property (setWr && lastWren && !eraseArm |=> stall [*3] ##1 !stall)
		else $error("write stall length wrong");
	AST_ERASE_STALL: assert property (setWr && eraseArm |=> stall [*5] ##1 !stall)
		else $error("erase stall length wrong");
	AST_NO_TRIG: assert property (setWr && !lastWren |=> !stall)
		else $error("trigger without enable started work");
	AST_ONLY_BITSET: assert property (!stall && !setRd && !setWr |=> !stall)
		else $error("stall without a trigger");
	AST_STALL_BOUND: assert property (stall |-> ##[1:5] !stall)
		else $error("stall too long");
	AST_ADDR_READ: assert property (!stall && op == fdm_pkg::OP_READ
		&& sel == fdm_pkg::SEL_ADDR |=> rdData == {2'h0, addrReg})
		else $error("address register readback wrong");
	AST_CTRL_CLEAR: assert property (!stall && op == fdm_pkg::OP_READ
		&& sel == fdm_pkg::SEL_CTRL && !lastFree && !lastWren
		|=> rdData[4] == 1'b0 && rdData[2] == 1'b0)
		else $error("unlock bit left set");
endmodule

// File: bench/tb.sv
// testbench: core and controller joined back to back
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic reqValid = 1'b0;
	logic [1:0] reqOp = 2'h0;
	logic [1:0] reqSel = 2'h0;
	logic [fdm_pkg::BIT_W-1:0] reqBit = 3'h0;
	logic [7:0] reqData = 8'h00;
	logic reqReady;
	logic [7:0] rspData;
	int n_fail = 0;
	int compares = 0;
	fdm_if bus();
	fdm_ctrl fdm_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus));
	fdm_core fdm_core_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .reqValid(reqValid),
		.reqOp(reqOp), .reqSel(reqSel), .reqBit(reqBit), .reqData(reqData),
		.reqReady(reqReady), .rspData(rspData));
	fdm_asserts fdm_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n), .op(bus.op), .sel(bus.sel),
		.bitNum(bus.bitNum), .wrData(bus.wrData), .rdData(bus.rdData), .stall(bus.stall));
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic tally_and_finish;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// holds the request until the core takes it
	task automatic issue(input logic [1:0] o, input logic [1:0] s, input int b, input logic [7:0] d);
		int n;
		reqValid <= 1'b1;
		reqOp <= o;
		reqSel <= s;
		reqBit <= 3'(b);
		reqData <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (reqReady !== 1'b1 && n < 40);
		check({7'h00, reqReady}, 8'h01);
	endtask
	task automatic bset(input int b);
		issue(fdm_pkg::OP_BITSET, fdm_pkg::SEL_CTRL, b, 8'h00);
	endtask
	task automatic wreg(input logic [1:0] s, input logic [7:0] d);
		issue(fdm_pkg::OP_WRITE, s, 0, d);
	endtask
	task automatic idle;
		reqValid <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [1:0] s, input logic [7:0] e);
		issue(fdm_pkg::OP_READ, s, 0, 8'h00);
		reqValid <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check(rspData, e);
	endtask
	task automatic fread(input logic [7:0] a, input logic [7:0] e);
		wreg(fdm_pkg::SEL_ADDR, a);
		bset(fdm_pkg::BIT_RD);
		rd(fdm_pkg::SEL_DATA, e);
	endtask
	task automatic unlock;
		bset(fdm_pkg::BIT_ARRAY_WRITE_ENABLE_BIT);
		bset(fdm_pkg::BIT_WR);
		idle();
	endtask
	task automatic prog(input logic [7:0] a, input logic [7:0] d);
		wreg(fdm_pkg::SEL_ADDR, a);
		wreg(fdm_pkg::SEL_DATA, d);
		unlock();
	endtask
	task automatic t_erase;
		wreg(fdm_pkg::SEL_ADDR, 8'h15);
		bset(fdm_pkg::BIT_FREE);
		unlock();
		wreg(fdm_pkg::SEL_ADDR, 8'h1d);
		bset(fdm_pkg::BIT_FREE);
		unlock();
		fread(8'h10, 8'hff);
		fread(8'h17, 8'hff);
	endtask
	task automatic t_prog;
		prog(8'h12, 8'h5a);
		prog(8'h1b, 8'ha5);
		fread(8'h12, 8'h5a);
		fread(8'h13, 8'hff);
		fread(8'h1b, 8'ha5);
		prog(8'h12, 8'h0f);
		fread(8'h12, 8'h0a);
	endtask
	task automatic t_hold;
		wreg(fdm_pkg::SEL_ADDR, 8'h1b);
		rd(fdm_pkg::SEL_DATA, 8'h0a);
		rd(fdm_pkg::SEL_ADDR, 8'h1b);
		wreg(fdm_pkg::SEL_CTRL, 8'h01);
		rd(fdm_pkg::SEL_DATA, 8'h0a);
		rd(fdm_pkg::SEL_CTRL, 8'h00);
	endtask
	task automatic t_refuse;
		wreg(fdm_pkg::SEL_DATA, 8'h00);
		wreg(fdm_pkg::SEL_CTRL, 8'h04);
		bset(fdm_pkg::BIT_WR);
		idle();
		fread(8'h1b, 8'ha5);
		wreg(fdm_pkg::SEL_DATA, 8'h00);
		bset(fdm_pkg::BIT_ARRAY_WRITE_ENABLE_BIT);
		idle();
		idle();
		rd(fdm_pkg::SEL_CTRL, 8'h00);
		bset(fdm_pkg::BIT_WR);
		idle();
		fread(8'h1b, 8'ha5);
		wreg(fdm_pkg::SEL_ADDR, 8'h12);
		wreg(fdm_pkg::SEL_DATA, 8'hff);
		bset(fdm_pkg::BIT_FREE);
		idle();
		rd(fdm_pkg::SEL_CTRL, 8'h00);
		unlock();
		fread(8'h12, 8'h0a);
		wreg(fdm_pkg::SEL_ADDR, 8'h1c);
		wreg(fdm_pkg::SEL_CTRL, 8'h10);
		unlock();
		fread(8'h1b, 8'hff);
		wreg(fdm_pkg::SEL_ADDR, 8'h1b);
		wreg(fdm_pkg::SEL_DATA, 8'h3c);
		bset(fdm_pkg::BIT_FREE);
		bset(fdm_pkg::BIT_ARRAY_WRITE_ENABLE_BIT);
		idle();
		unlock();
		fread(8'h1b, 8'h3c);
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_erase();
		t_prog();
		t_hold();
		t_refuse();
		tally_and_finish();
	end
endmodule
